// file: dv/odc_cmd_props.sv
// Property checker for the display command interpreter
`timescale 1ns/1ns
module odc_cmd_props
    import odc_pkg::*;
(
    input wire logic i_clk,
    input wire logic i_rst,
    input wire logic i_cs_n,
    input wire logic i_v_line_override,
    input wire logic [5:0] o_horizontal_start_field,
    input wire logic [6:0] o_start_delay_tc,
    input wire logic o_memory_erase_busy,
    input wire logic o_oscillator_halt,
    input wire logic o_soft_reset_all,
    input wire logic [1:0] o_blank_size,
    input wire logic o_blink_reverse,
    input wire logic o_blink_phase,
    input wire logic o_reverse_video,
    input wire logic o_display_on,
    input wire logic o_line_count_choice,
    input wire logic o_internal_sync,
    input wire logic o_background_color_off,
    input wire logic o_burst_off,
    input wire logic o_frame_level_mode,
    input wire logic [3:0] o_line_a_target,
    input wire logic [3:0] o_line_b_target
);
    default clocking @(posedge i_clk); endclocking
    default disable iff (i_rst);
    delay_twice_a: assert property (o_start_delay_tc == {o_horizontal_start_field, 1'b0})
        else $error("start delay is not twice the field");
    reset_clear_a: assert property (disable iff (1'b0) i_rst |-> !o_display_on && o_blank_size == 2'b00
        && !o_soft_reset_all && o_line_a_target == 4'h0) else $error("settings not cleared in reset");
    osc_gate_a: assert property (o_oscillator_halt |-> !o_internal_sync && !o_display_on)
        else $error("oscillator halt outside its mode");
    burst_gate_a: assert property (o_burst_off |-> o_background_color_off && o_internal_sync)
        else $error("burst stop without background off");
    frame_gate_a: assert property (o_frame_level_mode |-> o_blank_size == 2'b10)
        else $error("frame level mode with wrong blanking");
    blink_rev_a: assert property (o_blink_reverse == (o_blink_phase && o_reverse_video))
        else $error("reverse blink mismatch");
    soft_clear_a: assert property (o_soft_reset_all |=> !o_display_on && o_blank_size == 2'b00)
        else $error("soft reset left settings");
    soft_hold_a: assert property (o_soft_reset_all && !i_cs_n |=> o_soft_reset_all)
        else $error("soft reset dropped with enable low");
    row_unique_a: assert property (o_line_a_target != 4'h0 && o_line_a_target <= ROW_MAX
        |-> o_line_a_target != o_line_b_target) else $error("two line entries share a row");
    erase_gate_a: assert property ($rose(o_memory_erase_busy) |-> !o_display_on ##1 o_memory_erase_busy [*8])
        else $error("erase started with display on or ended early");
    v_override_a: assert property ($rose(i_v_line_override) |-> ##[0:3] o_line_count_choice)
        else $error("line override ignored");
endmodule
bind odc_cmd odc_cmd_props u_props (.*);

// file: dv/odc_host.sv
// Host model writing serial command bytes
`timescale 1ns/1ns
module odc_host (
    output logic o_sclk,
    output logic o_cs_n,
    output logic o_sin
);
    // Link clock idles high, it stands still between bytes
    initial begin
        o_sclk = 1'b1;
        o_cs_n = 1'b1;
        o_sin = 1'b1;
    end
    // Caller sets bit 7: one on first bytes, zero on data bytes
    task automatic put(input logic [7:0] b);
        #3;
        if (o_cs_n) begin
            o_cs_n = 1'b0;
            #256;
        end
        for (int i = 7; i >= 0; i--) begin
            o_sclk = 1'b0;
            o_sin = b[i];
            #32;
            o_sclk = 1'b1;
            #32;
        end
        // Data line no longer valid after hold time
        o_sin = ~o_sin;
        #640;
    endtask
    task automatic release_cs();
        #2000;
        o_cs_n = 1'b1;
        #2000;
    endtask
endmodule

// file: dv/test_odc_cmd.sv
// Self-checking bench for the display command interpreter
`timescale 1ns/1ns
module test_odc_cmd;
    import odc_pkg::*;
    logic i_clk = 1'b0;
    logic i_rst;
    logic i_v_line_override = 1'b0;
    logic i_sclk, i_cs_n, i_sin;
    logic [1:0] o_line1_width, o_line2_width, o_blank_size, o_separator_output_pin;
    logic [5:0] o_horizontal_start_field;
    logic [6:0] o_start_delay_tc;
    logic [3:0] o_line_a_target, o_line_b_target, o_line_c_target;
    logic [2:0] o_background_hue, o_line_a_hue, o_line_b_hue, o_line_c_hue;
    logic o_dot_clock_source, o_test_mode_bit, o_memory_erase_busy, o_oscillator_halt, o_soft_reset_all;
    logic o_fill_area_choice, o_blink_enable, o_blink_period, o_blink_phase, o_blink_reverse, o_reverse_video;
    logic o_display_on, o_color_system_choice, o_line_count_choice, o_scan_type_choice, o_internal_sync;
    logic o_background_level_choice, o_partial_internal_sync, o_background_color_off, o_burst_off;
    logic o_row_count_choice, o_video_silence, o_cr_area_choice, o_cr_output_enable, o_v_edge_polarity;
    logic o_v_separation_length, o_mask_clear, o_vsync_mask_length, o_frame_level_mode;
    logic [26:0] expq[$];
    int n_errors = 0;
    int checked = 0;
    logic smp = 1'b0;
    logic [31:0] r;
    logic [7:0] s, c;
    logic [23:0] e;
    odc_host host (.o_sclk(i_sclk), .o_cs_n(i_cs_n), .o_sin(i_sin));
    odc_cmd dut (.*);
    always #5 i_clk = ~i_clk;
    ////////////////////////////////////////////////////////////////////////////
    function automatic logic [23:0] view(input logic [2:0] g);
        case (g)
            0: return {o_line2_width, o_line1_width, o_dot_clock_source, o_horizontal_start_field, o_start_delay_tc};
            1: return {o_test_mode_bit, o_fill_area_choice, o_blank_size, o_blink_period, o_blink_enable,
                o_reverse_video, o_display_on};
            2: return {o_color_system_choice, o_line_count_choice, o_scan_type_choice, o_internal_sync,
                o_background_level_choice, o_partial_internal_sync, o_background_color_off, o_burst_off,
                o_background_hue};
            3: return {o_separator_output_pin, o_row_count_choice, o_video_silence};
            4: return {o_cr_area_choice, o_cr_output_enable, o_v_edge_polarity, o_v_separation_length,
                o_mask_clear, o_vsync_mask_length, o_frame_level_mode};
            5: return {o_line_a_target, o_line_a_hue, o_line_b_target, o_line_b_hue, o_line_c_target, o_line_c_hue};
            default: return {o_blink_reverse, o_blink_phase, o_soft_reset_all, o_oscillator_halt, o_memory_erase_busy};
        endcase
    endfunction
    task automatic chk(input logic [23:0] seen, input logic [23:0] exp);
        checked++;
        if (seen !== exp) begin
            n_errors++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    // Settings land within 4 clocks; the host gap is far longer
    task automatic note(input logic [2:0] g, input logic [23:0] v);
        repeat (2) @(negedge i_clk);
        expq.push_back({g, v});
        smp = ~smp;
    endtask
    always @(smp) begin
        logic [26:0] n;
        n = expq.pop_front();
        chk(view(n[26:24]), n[23:0]);
    end
    task automatic cmd(input logic [7:0] f, input logic [7:0] d);
        host.put(f);
        host.put(d);
    endtask
    task automatic stop_test();
        $display("mismatches %0d of %0d checks", n_errors, checked);
        if (n_errors == 0 && checked > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////////////
    initial begin
        #900000;
        n_errors++;
        stop_test();
    end
    initial begin
        i_rst = 1'b1;
        r = $urandom(32'h36a6);
        repeat (3) @(negedge i_clk);
        i_rst = 1'b0;
        for (int g = 0; g < 7; g++) note(3'(g), 24'h0);
        $display("reset test done");
        r = $urandom;
        host.put({ID_HORZ, r[3:0]});
        repeat (4) begin
            s = {1'b0, 7'($urandom)};
            host.put(s);
            note(0, {r[3:0], s[6], s[5:0], s[5:0], 1'b0});
        end
        $display("horizontal test done");
        // Test mode bit always written as zero
        s = {1'b0, r[6], 2'b10, r[3:1], 1'b0};
        cmd({ID_DISP, 4'h0}, s);
        note(1, {1'b0, s[6:0]});
        c = {1'b0, r[13:8], 1'b1};
        cmd({ID_EXT, SUB_CHROMA}, c);
        note(4, c[6:0]);
        cmd({ID_DISP, 4'h0}, {1'b0, r[6], 2'b00, r[3:1], 1'b0});
        note(4, {c[6:1], 1'b0});
        $display("display test done");
        for (int k = 0; k < 4; k++) begin
            r = $urandom;
            i_v_line_override = k[0];
            cmd({ID_FMT, r[3:0]}, {1'b0, r[10:4]});
            e = {r[3], r[2] | k[0], r[1:0], r[10:9], r[8] & r[0], r[7] & r[8] & r[0], r[6:4]};
            note(2, e);
        end
        // Enable high drops the stored identifier
        host.release_cs();
        host.put({1'b0, ~r[10:4]});
        note(2, e);
        i_v_line_override = 1'b0;
        for (int k = 0; k < 4; k++) begin
            r = $urandom;
            cmd({ID_SYNC, 2'(k), r[1:0]}, {1'b0, r[8:2]});
            note(3, {2'(k), r[1:0]});
        end
        $display("format test done");
        cmd({ID_EXT, SUB_LINE_A}, {1'b0, 4'd5, 3'd3});
        cmd({ID_EXT, SUB_LINE_C}, {1'b0, ROW_MAX, 3'd7});
        cmd({ID_EXT, SUB_LINE_B}, {1'b0, 4'd5, 3'd6});
        note(5, {7'h00, 4'd5, 3'd6, ROW_MAX, 3'd7});
        cmd({ID_EXT, 4'h7}, {1'b0, 4'd1, 3'd1});
        note(5, {7'h00, 4'd5, 3'd6, ROW_MAX, 3'd7});
        $display("line test done");
        host.put({ID_FMT, 4'h0});
        host.put({ID_DISP, 4'h2});
        note(6, 24'h2);
        host.put({ID_DISP, 4'h4});
        note(6, 24'h1);
        repeat (ERASE_CYC - 300) @(negedge i_clk);
        note(6, 24'h1);
        repeat (400) @(negedge i_clk);
        note(6, 24'h0);
        cmd({ID_DISP, 4'h0}, 8'h01);
        host.put({ID_DISP, 4'h6});
        note(6, 24'h0);
        $display("erase test done");
        host.put({ID_DISP, 4'h1});
        note(6, 24'h4);
        host.release_cs();
        for (int g = 0; g < 7; g++) note(3'(g), 24'h0);
        $display("soft reset test done");
        stop_test();
    end
endmodule

// file: hw/odc_byte_rx.sv
// Serial byte receiver on the link clock, handing bytes over by toggle
`timescale 1ns/1ns
module odc_byte_rx
    import odc_pkg::*;
(
    input wire logic i_sclk,
    input wire logic i_rst,
    input wire logic i_cs_n,
    input wire logic i_sin,
    output logic [DATA_W-1:0] o_byte,
    output logic o_toggle
);
    logic [2:0] cnt_reg;
    logic [2:0] cnt_next;
    logic [DATA_W-1:0] sh_reg;
    logic [DATA_W-1:0] sh_next;
    logic [DATA_W-1:0] byte_reg;
    logic [DATA_W-1:0] byte_next;
    logic tog_reg;
    logic tog_next;

    // CS high clears the bit count asynchronously, since the link clock stops between frames
    always_comb begin
        sh_next = {sh_reg[DATA_W-2:0], i_sin};
        cnt_next = cnt_reg + 3'h1;
        byte_next = byte_reg;
        tog_next = tog_reg;
        if (cnt_reg == 3'h7) begin
            byte_next = {sh_reg[DATA_W-2:0], i_sin};
            tog_next = ~tog_reg;
        end
    end

    always_ff @(posedge i_sclk or posedge i_rst or posedge i_cs_n) begin
        if (i_rst) begin
            cnt_reg <= 3'h0;
        end else if (i_cs_n) begin
            cnt_reg <= 3'h0;
        end else begin
            cnt_reg <= cnt_next;
        end
    end

    // Count stays at zero while deselected, so no byte completes then
    always_ff @(posedge i_sclk or posedge i_rst) begin
        if (i_rst) begin
            sh_reg <= '0;
            byte_reg <= '0;
            tog_reg <= 1'b0;
        end else begin
            sh_reg <= sh_next;
            byte_reg <= byte_next;
            tog_reg <= tog_next;
        end
    end

    assign o_byte = byte_reg;
    assign o_toggle = tog_reg;
endmodule

// file: hw/odc_cmd.sv
// Display control command interpreter: decodes two-byte commands into settings
// How it works
// (RL1) Two 2-bit horizontal size fields, one per line
// (RL2) Bit 7 zero marks a data byte
// (RL3) Second byte bit 6 picks dot clock
// (RL4) Horizontal start delay is twice field
// (RL5) Reset pin clears every setting
// (RL6) Host keeps test mode bit zero
// (RL7) Erase fills memory, about 500 us
// (RL8) Oscillator halt only external sync, display off
// (RL9) Soft reset held while enable low
// (RL10) Blank size and fill-in area choice
// (RL11) Blink enable and period, reverse alternation
// (RL12) Display on and reverse video bits
// (RL13) Format, lines, scan, sync source settings
// (RL14) Background level and partial internal sync
// (RL15) Background off and burst stop gating
// (RL16) Three-bit background hue code
// (RL17) Separator output select and row count
// (RL18) Mute cuts video to pedestal
// (RL19) Chroma switch area, enable, V edge
// (RL20) V separation length and mask controls
// (RL21) Frame level mode gated by blanking
// (RL22) Line colour, latest same-row command wins
// (RL23) Identifier kept until next first byte
// (RL24) Enable high returns to address setup
// (RL25) Unknown identifiers change nothing
`timescale 1ns/1ns
module odc_cmd
    import odc_pkg::*;
(
    input wire logic i_clk,
    input wire logic i_rst,
    input wire logic i_sclk,
    input wire logic i_cs_n,
    input wire logic i_sin,
    input wire logic i_v_line_override,
    output logic [1:0] o_line1_width,
    output logic [1:0] o_line2_width,
    output logic o_dot_clock_source,
    output logic [5:0] o_horizontal_start_field,
    output logic [6:0] o_start_delay_tc,
    output logic o_test_mode_bit,
    output logic o_memory_erase_busy,
    output logic o_oscillator_halt,
    output logic o_soft_reset_all,
    output logic [1:0] o_blank_size,
    output logic o_fill_area_choice,
    output logic o_blink_enable,
    output logic o_blink_period,
    output logic o_blink_phase,
    output logic o_blink_reverse,
    output logic o_reverse_video,
    output logic o_display_on,
    output logic o_color_system_choice,
    output logic o_line_count_choice,
    output logic o_scan_type_choice,
    output logic o_internal_sync,
    output logic o_background_level_choice,
    output logic o_partial_internal_sync,
    output logic o_background_color_off,
    output logic o_burst_off,
    output logic [2:0] o_background_hue,
    output logic [1:0] o_separator_output_pin,
    output logic o_row_count_choice,
    output logic o_video_silence,
    output logic o_cr_area_choice,
    output logic o_cr_output_enable,
    output logic o_v_edge_polarity,
    output logic o_v_separation_length,
    output logic o_mask_clear,
    output logic o_vsync_mask_length,
    output logic o_frame_level_mode,
    output logic [3:0] o_line_a_target,
    output logic [2:0] o_line_a_hue,
    output logic [3:0] o_line_b_target,
    output logic [2:0] o_line_b_hue,
    output logic [3:0] o_line_c_target,
    output logic [2:0] o_line_c_hue
);
    ////////////////////////////////////////////////////////////////////////
    // Link domain and crossings
    logic [DATA_W-1:0] rx_byte;
    logic rx_tog;
    logic [2:0] tog_sync_reg;
    logic [1:0] cs_sync_reg;
    logic [1:0] vov_sync_reg;
    logic v_override;
    logic cs_high;
    logic byte_strobe;

    odc_byte_rx u_rx (
        .i_sclk(i_sclk),
        .i_rst(i_rst),
        .i_cs_n(i_cs_n),
        .i_sin(i_sin),
        .o_byte(rx_byte),
        .o_toggle(rx_tog)
    );

    // Byte register is stable for 8 link clocks after the toggle, long enough to sample
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            tog_sync_reg <= 3'h0;
            cs_sync_reg <= 2'b11;
            vov_sync_reg <= 2'b00;
        end else begin
            tog_sync_reg <= {tog_sync_reg[1:0], rx_tog};
            cs_sync_reg <= {cs_sync_reg[0], i_cs_n};
            vov_sync_reg <= {vov_sync_reg[0], i_v_line_override};
        end
    end
    assign byte_strobe = tog_sync_reg[2] ^ tog_sync_reg[1];
    assign cs_high = cs_sync_reg[1];
    // External V pin is asynchronous to the settings clock
    assign v_override = vov_sync_reg[1];

    ////////////////////////////////////////////////////////////////////////
    // Settings registers
    logic [3:0] id_reg, id_next;
    logic [3:0] sub_reg, sub_next;
    logic [10:0] horz_reg, horz_next;
    logic [10:0] disp_reg, disp_next;
    logic [10:0] fmt_reg, fmt_next;
    logic [10:0] sync_reg, sync_next;
    logic [6:0] chroma_reg, chroma_next;
    logic [6:0] lin_a_reg, lin_a_next;
    logic [6:0] lin_b_reg, lin_b_next;
    logic [6:0] lin_c_reg, lin_c_next;
    logic srst_reg, srst_next;
    logic [$clog2(ERASE_CYC+1)-1:0] erase_reg, erase_next;
    logic [6:0] data7;
    logic [6:0] nl;

    // True when a line command targets a real row equal to another slot's row
    function automatic logic same_row(input logic [3:0] a, input logic [3:0] b);
        same_row = (a != ROW_NONE) && (a <= ROW_MAX) && (a == b);
    endfunction

    always_comb begin
        id_next = id_reg;
        sub_next = sub_reg;
        horz_next = horz_reg;
        disp_next = disp_reg;
        fmt_next = fmt_reg;
        sync_next = sync_reg;
        chroma_next = chroma_reg;
        lin_a_next = lin_a_reg;
        lin_b_next = lin_b_reg;
        lin_c_next = lin_c_reg;
        srst_next = srst_reg;
        erase_next = erase_reg;
        data7 = rx_byte[6:0];
        nl = RST_NARROW;
        // Only the erase time is counted; the memory itself lives elsewhere
        if (erase_reg != '0) begin
            erase_next = erase_reg - 1'b1;
        end
        if (cs_high) begin
            id_next = ID_ADDR; // (RL24)
            sub_next = 4'h0;
            srst_next = 1'b0; // (RL9)
        end else if (byte_strobe) begin
            if (rx_byte[SEL_BIT]) begin // (RL2)
                id_next = rx_byte[ID_HI:ID_LO]; // (RL23)
                sub_next = rx_byte[ID_LO-1:0];
                if (rx_byte[ID_HI:ID_LO] == ID_DISP) begin
                    disp_next[3:0] = rx_byte[3:0];
                    // Erase asked with display on is dropped, not deferred
                    if (rx_byte[B_ERASE] && !disp_reg[4]) begin
                        erase_next = ($clog2(ERASE_CYC+1))'(ERASE_CYC); // (RL7)
                    end
                    if (rx_byte[B_SOFTRST]) begin
                        srst_next = 1'b1; // (RL9)
                    end
                end else if (rx_byte[ID_HI:ID_LO] == ID_HORZ) begin
                    horz_next[10:7] = rx_byte[3:0]; // (RL1)
                end else if (rx_byte[ID_HI:ID_LO] == ID_FMT) begin
                    fmt_next[10:7] = rx_byte[3:0]; // (RL13)
                end else if (rx_byte[ID_HI:ID_LO] == ID_SYNC) begin
                    sync_next[10:7] = rx_byte[3:0]; // (RL17) (RL18)
                end
            end else begin
                case (id_reg)
                    ID_HORZ: horz_next[6:0] = data7; // (RL3) (RL4)
                    ID_DISP: disp_next[10:4] = data7; // (RL10) (RL11) (RL12)
                    ID_FMT: fmt_next[6:0] = data7; // (RL14) (RL15) (RL16)
                    ID_SYNC: sync_next[6:0] = data7;
                    ID_EXT: begin
                        case (sub_reg)
                            SUB_CHROMA: chroma_next = data7; // (RL19) (RL20) (RL21)
                            // Latest command for a row wins, older slot clears (RL22)
                            SUB_LINE_A: begin
                                lin_a_next = data7;
                                if (same_row(data7[6:3], lin_b_reg[6:3])) lin_b_next = nl;
                                if (same_row(data7[6:3], lin_c_reg[6:3])) lin_c_next = nl;
                            end
                            SUB_LINE_B: begin
                                lin_b_next = data7;
                                if (same_row(data7[6:3], lin_a_reg[6:3])) lin_a_next = nl;
                                if (same_row(data7[6:3], lin_c_reg[6:3])) lin_c_next = nl;
                            end
                            SUB_LINE_C: begin
                                lin_c_next = data7;
                                if (same_row(data7[6:3], lin_a_reg[6:3])) lin_a_next = nl;
                                if (same_row(data7[6:3], lin_b_reg[6:3])) lin_b_next = nl;
                            end
                            default: ; // (RL25)
                        endcase
                    end
                    default: ; // (RL25)
                endcase
            end
        end
        // Soft reset holds all settings cleared while enable stays low
        if (srst_next) begin
            horz_next = RST_WIDE; // (RL9)
            disp_next = RST_WIDE;
            fmt_next = RST_WIDE;
            sync_next = RST_WIDE;
            chroma_next = RST_NARROW;
            lin_a_next = RST_NARROW;
            lin_b_next = RST_NARROW;
            lin_c_next = RST_NARROW;
        end
    end

    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            id_reg <= ID_ADDR; // (RL5)
            sub_reg <= 4'h0;
            horz_reg <= RST_WIDE;
            disp_reg <= RST_WIDE;
            fmt_reg <= RST_WIDE;
            sync_reg <= RST_WIDE;
            chroma_reg <= RST_NARROW;
            lin_a_reg <= RST_NARROW;
            lin_b_reg <= RST_NARROW;
            lin_c_reg <= RST_NARROW;
            srst_reg <= 1'b0;
            erase_reg <= '0;
        end else begin
            id_reg <= id_next;
            sub_reg <= sub_next;
            horz_reg <= horz_next;
            disp_reg <= disp_next;
            fmt_reg <= fmt_next;
            sync_reg <= sync_next;
            chroma_reg <= chroma_next;
            lin_a_reg <= lin_a_next;
            lin_b_reg <= lin_b_next;
            lin_c_reg <= lin_c_next;
            srst_reg <= srst_next;
            erase_reg <= erase_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Blink timer
    logic [$clog2(BLINK_SHORT_CYC)-1:0] bcnt_reg, bcnt_next;
    logic [1:0] bph_reg, bph_next;

    always_comb begin
        bcnt_next = bcnt_reg + 1'b1;
        bph_next = bph_reg;
        // Phase restarts whenever blinking is switched off
        if (!disp_reg[6]) begin
            bcnt_next = '0;
            bph_next = 2'h0;
        end else if (bcnt_reg == ($clog2(BLINK_SHORT_CYC))'(BLINK_SHORT_CYC - 1)) begin
            bcnt_next = '0;
            bph_next = bph_reg + 2'h1;
        end
    end

    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            bcnt_reg <= '0;
            bph_reg <= 2'h0;
        end else begin
            bcnt_reg <= bcnt_next;
            bph_reg <= bph_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Outputs
    // Horizontal size and start
    assign o_line2_width = horz_reg[10:9]; // (RL1)
    assign o_line1_width = horz_reg[8:7];
    assign o_dot_clock_source = horz_reg[B_CLKSRC]; // (RL3)
    assign o_horizontal_start_field = horz_reg[5:0];
    assign o_start_delay_tc = {horz_reg[5:0], 1'b0}; // (RL4)

    // Display control
    assign o_test_mode_bit = disp_reg[3]; // (RL6)
    assign o_memory_erase_busy = (erase_reg != '0); // (RL7)
    assign o_oscillator_halt = disp_reg[B_OSCHALT] & ~fmt_reg[7] & ~disp_reg[4]; // (RL8)
    assign o_soft_reset_all = srst_reg;
    assign o_fill_area_choice = disp_reg[10]; // (RL10)
    assign o_blank_size = disp_reg[9:8];
    assign o_blink_period = disp_reg[7]; // (RL11)
    assign o_blink_enable = disp_reg[6];
    assign o_blink_phase = disp_reg[6] & (disp_reg[7] ? bph_reg[1] : bph_reg[0]);
    assign o_blink_reverse = o_blink_phase & disp_reg[5];
    assign o_reverse_video = disp_reg[5]; // (RL12)
    assign o_display_on = disp_reg[4];

    // Video format and background
    assign o_color_system_choice = fmt_reg[10]; // (RL13)
    assign o_line_count_choice = fmt_reg[9] | v_override; // (RL13)
    assign o_scan_type_choice = fmt_reg[8];
    assign o_internal_sync = fmt_reg[7];
    assign o_background_level_choice = fmt_reg[6]; // (RL14)
    assign o_partial_internal_sync = fmt_reg[5];
    assign o_background_color_off = fmt_reg[4] & fmt_reg[7]; // (RL15)
    assign o_burst_off = fmt_reg[3] & o_background_color_off;
    assign o_background_hue = fmt_reg[2:0]; // (RL16)

    // Sync detection
    assign o_separator_output_pin = sync_reg[10:9]; // (RL17)
    assign o_row_count_choice = sync_reg[8];
    assign o_video_silence = sync_reg[7]; // (RL18)

    // Chroma switch and masks
    assign o_cr_area_choice = chroma_reg[6]; // (RL19)
    assign o_cr_output_enable = chroma_reg[5];
    assign o_v_edge_polarity = chroma_reg[4];
    assign o_v_separation_length = chroma_reg[3]; // (RL20)
    assign o_mask_clear = chroma_reg[2];
    assign o_vsync_mask_length = chroma_reg[1];
    assign o_frame_level_mode = chroma_reg[0] & ~disp_reg[8] & disp_reg[9]; // (RL21)

    // Line backgrounds
    assign o_line_a_target = lin_a_reg[6:3]; // (RL22)
    assign o_line_a_hue = lin_a_reg[2:0];
    assign o_line_b_target = lin_b_reg[6:3];
    assign o_line_b_hue = lin_b_reg[2:0];
    assign o_line_c_target = lin_c_reg[6:3];
    assign o_line_c_hue = lin_c_reg[2:0];
endmodule

// file: hw/odc_pkg.sv
// Constants for the display command interpreter
package odc_pkg;
    localparam int DATA_W = 8;
    localparam int ID_HI = 7;
    localparam int ID_LO = 4;
    localparam int SEL_BIT = 7;

    // First-byte identifier nibbles
    localparam logic [3:0] ID_ADDR = 4'h8;
    localparam logic [3:0] ID_HORZ = 4'hb;
    localparam logic [3:0] ID_DISP = 4'hc;
    localparam logic [3:0] ID_FMT = 4'hd;
    localparam logic [3:0] ID_SYNC = 4'he;
    localparam logic [3:0] ID_EXT = 4'hf;
    // Low nibble codes under the extended identifier
    localparam logic [3:0] SUB_CHROMA = 4'h0;
    localparam logic [3:0] SUB_LINE_A = 4'h1;
    localparam logic [3:0] SUB_LINE_B = 4'h2;
    localparam logic [3:0] SUB_LINE_C = 4'h3;

    localparam logic [10:0] RST_WIDE = 11'h000;
    localparam logic [6:0] RST_NARROW = 7'h00;
    localparam logic [3:0] ROW_NONE = 4'h0;
    localparam logic [3:0] ROW_MAX = 4'hc;

    // Bit positions: B_CLKSRC in the second byte, the rest in the display first byte
    localparam int B_CLKSRC = 6;
    localparam int B_ERASE = 2;
    localparam int B_OSCHALT = 1;
    localparam int B_SOFTRST = 0;

    // Erase time and blink halves
    localparam int CLK_MHZ = 100;
    localparam int ERASE_US = 500;
    localparam int ERASE_CYC = ERASE_US * CLK_MHZ;
    localparam int BLINK_SHORT_MS = 250;
    localparam int BLINK_SHORT_CYC = BLINK_SHORT_MS * 1000 * CLK_MHZ;
endpackage
